//--- include/pms_pkg.sv
// constants and state type for the pin strap and interrupt block
package pms_pkg;
  localparam logic [4:0] PMS_ADDR_IRQ_CTRL = 5'h1B;
  localparam logic [4:0] PMS_ADDR_CTRL_TWO = 5'h1F;
  localparam int PMS_IRQ_EN_LSB = 8;
  localparam int PMS_IRQ_ST_LSB = 0;
  localparam int PMS_IRQ_POL_BIT = 9;
  localparam int PMS_IRQ_W = 8;
  localparam logic [7:0] PMS_IRQ_EN_RST = 8'h00;
  localparam logic [7:0] PMS_IRQ_ST_RST = 8'h00;
  localparam logic PMS_IRQ_POL_RST = 1'b0;
  localparam logic PMS_IRQ_PIN_RST = 1'b1;
  localparam logic [15:0] PMS_RD_RST = 16'h0000;
  localparam logic [2:0] PMS_MODE_RST = 3'h0;

  typedef struct packed {
    logic strapDone;
    logic settingA;
    logic [2:0] modeStrap;
    logic [PMS_IRQ_W-1:0] irqEnable;
    logic [PMS_IRQ_W-1:0] irqStatus;
    logic irqPolHigh;
    logic [15:0] rdData;
    logic rxErr;
    logic col;
    logic crs;
    logic rxDv;
    logic outEn;
    logic irqPin;
    logic txEn;
    logic [3:0] txData;
  } pms_state_t;
endpackage

//--- hdl/pms_pin_strap.sv
// MAC-facing pins: strap capture, pin direction, interrupt register and pin polarity
// What this block does
// - after reset, receive-error pin level is caught and held as setting_a setting
// - after reset, collision pin level is caught as mode strap bit zero
// - after reset, carrier-sense pin level is caught as mode strap bit one
// - register 1Bh enables interrupt conditions and shows pending ones
// - bit 9 of phy_control_two makes the interrupt pin active high
// - after reset, receive-data-valid pin level is caught as mode strap bit two
module pms_pin_strap
  import pms_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic rmiiMode,
  input wire logic [4:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  input wire logic [PMS_IRQ_W-1:0] irqEvents,
  output logic irq_output_pin,
  input wire logic rxErrSrc,
  input wire logic colSrc,
  input wire logic crsSrc,
  input wire logic rxDvSrc,
  input wire logic receive_error_in,
  output logic receive_error_out,
  output logic receive_error_oe,
  input wire logic colPinIn,
  output logic colPinOut,
  output logic colPinOe,
  input wire logic crsPinIn,
  output logic crsPinOut,
  output logic crsPinOe,
  input wire logic rxDvPinIn,
  output logic rxDvPinOut,
  output logic rxDvPinOe,
  input wire logic txEnPin,
  input wire logic [3:0] txDataPin,
  output logic txEnOut,
  output logic [3:0] txDataOut,
  output logic setting_a,
  output logic [2:0] modeStrap,
  output logic strapDone
);

  pms_state_t st_ff;
  pms_state_t nxt_st;

  // pin level for a given pending state and polarity
  function automatic logic irqLevel(input logic pend, input logic polHigh);
    return polHigh ? pend : ~pend;
  endfunction

  // one address decoder for every register strobe
  function automatic logic regHit(input logic strobe, input logic [4:0] addr,
      input logic [4:0] target);
    return strobe && (addr == target);
  endfunction

  logic irqPending;
  logic irqRead;
  logic irqWrHit;
  logic polWrHit;
  assign irqPending = |(st_ff.irqStatus & st_ff.irqEnable);
  assign irqRead = regHit(regRdEn, regAddr, PMS_ADDR_IRQ_CTRL);
  assign irqWrHit = regHit(regWrEn, regAddr, PMS_ADDR_IRQ_CTRL);
  assign polWrHit = regHit(regWrEn, regAddr, PMS_ADDR_CTRL_TWO);

  always_comb begin
    nxt_st = st_ff;
    // straps are caught one cycle after release; pins stay inputs until the cycle after that
    if (!st_ff.strapDone) begin
      nxt_st.strapDone = 1'b1;
      nxt_st.settingA = receive_error_in;
      nxt_st.modeStrap[0] = colPinIn;
      nxt_st.modeStrap[1] = crsPinIn;
      nxt_st.modeStrap[2] = rxDvPinIn;
    end
    // setting_a keeps the MAC-side outputs floating
    nxt_st.outEn = st_ff.strapDone && !st_ff.settingA;
    nxt_st.rxErr = rxErrSrc;
    nxt_st.col = colSrc;
    nxt_st.crs = crsSrc;
    nxt_st.rxDv = rxDvSrc;
    nxt_st.txEn = txEnPin;
    // upper data pins are don't-care in RMII
    nxt_st.txData = rmiiMode ? {2'h0, txDataPin[1:0]} : txDataPin;
    if (irqWrHit) begin
      nxt_st.irqEnable = regWrData[PMS_IRQ_EN_LSB +: PMS_IRQ_W];
    end
    if (polWrHit) begin
      nxt_st.irqPolHigh = regWrData[PMS_IRQ_POL_BIT];
    end
    // status clears on read, a same-cycle event still sets
    nxt_st.irqStatus = (irqRead ? '0 : st_ff.irqStatus) | irqEvents;
    if (regRdEn) begin
      case (regAddr)
        PMS_ADDR_IRQ_CTRL: nxt_st.rdData = {st_ff.irqEnable, st_ff.irqStatus};
        PMS_ADDR_CTRL_TWO: nxt_st.rdData = 16'(st_ff.irqPolHigh) << PMS_IRQ_POL_BIT;
        default: nxt_st.rdData = PMS_RD_RST;
      endcase
    end
    nxt_st.irqPin = irqLevel(irqPending, st_ff.irqPolHigh);
  end

  // sync reset only: a pulse in mid-run re-arms the strap capture
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_ff.strapDone <= 1'b0;
      st_ff.settingA <= 1'b0;
      st_ff.modeStrap <= PMS_MODE_RST;
      st_ff.irqEnable <= PMS_IRQ_EN_RST;
      st_ff.irqStatus <= PMS_IRQ_ST_RST;
      st_ff.irqPolHigh <= PMS_IRQ_POL_RST;
      st_ff.rdData <= PMS_RD_RST;
      st_ff.rxErr <= 1'b0;
      st_ff.col <= 1'b0;
      st_ff.crs <= 1'b0;
      st_ff.rxDv <= 1'b0;
      st_ff.outEn <= 1'b0;
      st_ff.irqPin <= PMS_IRQ_PIN_RST;
      st_ff.txEn <= 1'b0;
      st_ff.txData <= 4'h0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regRdData = st_ff.rdData;
  assign irq_output_pin = st_ff.irqPin;
  assign receive_error_out = st_ff.rxErr;
  // one enable for all four pins, so they float and drive together
  assign receive_error_oe = st_ff.outEn;
  assign colPinOut = st_ff.col;
  assign colPinOe = st_ff.outEn;
  assign crsPinOut = st_ff.crs;
  assign crsPinOe = st_ff.outEn;
  assign rxDvPinOut = st_ff.rxDv;
  assign rxDvPinOe = st_ff.outEn;
  assign txEnOut = st_ff.txEn;
  assign txDataOut = st_ff.txData;
  assign setting_a = st_ff.settingA;
  assign modeStrap = st_ff.modeStrap;
  assign strapDone = st_ff.strapDone;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // strap capture and pin direction
  a_iso_strap_cap: assert property (
    !strapDone |=> setting_a == $past(receive_error_in) && strapDone)
    else $error("setting_a strap not taken from receive-error pin");
  a_iso_no_drive: assert property (
    (!strapDone || setting_a) |=> !receive_error_oe && !colPinOe && !crsPinOe
    && !rxDvPinOe)
    else $error("MAC-side pin driven before strap or while isolated");
  a_iso_all_off: assert property (
    setting_a |-> !receive_error_oe && !colPinOe && !crsPinOe && !rxDvPinOe)
    else $error("isolated pins are driving");
  a_oe_after_strap: assert property (
    strapDone && !setting_a |=> receive_error_oe && colPinOe && crsPinOe && rxDvPinOe)
    else $error("MAC-side pins not driven after strap capture");
  a_rx_err_path: assert property (
    strapDone |=> receive_error_out == $past(rxErrSrc))
    else $error("receive-error output does not follow its source");
  a_mode0_cap: assert property (
    !strapDone |=> modeStrap[0] == $past(colPinIn))
    else $error("mode strap bit 0 not taken from collision pin");
  a_mode1_cap: assert property (
    !strapDone |=> modeStrap[1] == $past(crsPinIn))
    else $error("mode strap bit 1 not taken from carrier-sense pin");
  a_mode2_cap: assert property (
    !strapDone |=> modeStrap[2] == $past(rxDvPinIn))
    else $error("mode strap bit 2 not taken from data-valid pin");
  a_strap_hold: assert property (
    strapDone |=> $stable(modeStrap) && $stable(setting_a))
    else $error("strap values changed after capture");

  // register and interrupt path
  a_irq_en_wr: assert property (
    regWrEn && regAddr == PMS_ADDR_IRQ_CTRL ##1 regRdEn && regAddr == PMS_ADDR_IRQ_CTRL
    && !regWrEn |=> regRdData[15:8] == $past(regWrData[15:8], 2))
    else $error("interrupt enable readback wrong");
  a_irq_set_wins: assert property (
    irqRead && irqEvents[0] |=> st_ff.irqStatus[0])
    else $error("interrupt event lost on clear");
  a_irq_pol: assert property (
    st_ff.irqPolHigh && $stable(st_ff.irqPolHigh) && irqPending |=> irq_output_pin)
    else $error("active-high interrupt pin not asserted");
  a_irq_low_dflt: assert property (
    !st_ff.irqPolHigh && irqPending |=> !irq_output_pin)
    else $error("active-low interrupt pin not asserted");
  a_irq_sticky: assert property (
    !irqRead |=> st_ff.irqStatus == ($past(st_ff.irqStatus) | $past(irqEvents)))
    else $error("interrupt status lost without a read");
  a_irq_clear_rd: assert property (
    irqRead |=> st_ff.irqStatus == $past(irqEvents))
    else $error("interrupt status not cleared by read");
  a_unmapped_rd: assert property (
    regRdEn && regAddr != PMS_ADDR_IRQ_CTRL && regAddr != PMS_ADDR_CTRL_TWO
    |=> regRdData == PMS_RD_RST)
    else $error("unmapped read returned data");
  a_pol_wr: assert property (
    polWrHit |=> st_ff.irqPolHigh == $past(regWrData[PMS_IRQ_POL_BIT]))
    else $error("interrupt polarity write not taken");
  a_irq_idle: assert property (
    !irqPending |=> irq_output_pin == !$past(st_ff.irqPolHigh))
    else $error("idle interrupt pin at wrong level");

  // transmit side
  a_rmii_mask: assert property (
    rmiiMode |=> txDataOut[3:2] == 2'h0)
    else $error("upper transmit lines passed in reduced mode");
  a_tx_follow: assert property (
    !rmiiMode |=> txDataOut == $past(txDataPin) && txEnOut == $past(txEnPin))
    else $error("transmit pins not passed through");

  // main scenarios
  c_isolated: cover property (!strapDone ##1 setting_a);
  c_irq_high: cover property (st_ff.irqPolHigh && irq_output_pin);
  c_rmii_tx: cover property (rmiiMode && txDataPin[3]);
  c_rd_set_race: cover property (irqRead && irqEvents[0]);
  c_en_readback: cover property (irqWrHit ##1 irqRead);
endmodule // pms_pin_strap

//--- testbench/pms_mac_model.sv
// MAC-side model driving the transmit pins
module pms_mac_model (
  input wire logic core_clk,
  input wire logic rmiiMode,
  input wire logic txGo,
  input wire logic [3:0] txNib,
  output logic txEnPin,
  output logic [3:0] txDataPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // one upper line always high, so a missed mask shows at every sample
  logic [1:0] noise = 2'h1;
  always @(negedge core_clk) begin
    noise <= {noise[0], noise[1]};
    txEnPin <= txGo;
    // upper lines are undefined in RMII, so keep them moving
    txDataPin <= rmiiMode ? {noise, txNib[1:0]} : txNib;
  end
endmodule // pms_mac_model

//--- testbench/testbench.sv
// self-checking bench for the pin strap and interrupt block
module testbench;
  import pms_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0, srst = 1'b1, rmiiMode = 1'b0, regWrEn = 1'b0, regRdEn = 1'b0;
  logic txGo = 1'b0, txEnPin, txEnOut, strapDone, setting_a, irqPin;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWrData = 16'h0000, regRdData;
  logic [7:0] irqEvents = 8'h00;
  logic [3:0] src = 4'h0, pull = 4'h0, txNib = 4'h0, txDataPin, txDataOut, lvl;
  wire [3:0] oe, pout;
  logic [2:0] modeStrap;
  int badCount = 0, samplesChecked = 0, cycles = 0;
  // pulled strap level wins whenever the pin driver is off
  assign lvl = (oe & pout) | (~oe & pull);
  always #5 core_clk = ~core_clk;
  pms_mac_model pms_mac_model_inst (.core_clk(core_clk), .rmiiMode(rmiiMode), .txGo(txGo),
    .txNib(txNib), .txEnPin(txEnPin), .txDataPin(txDataPin));
  pms_pin_strap pms_pin_strap_inst (.core_clk(core_clk), .srst(srst), .rmiiMode(rmiiMode),
    .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData(regRdData), .irqEvents(irqEvents), .irq_output_pin(irqPin),
    .rxErrSrc(src[0]), .colSrc(src[1]), .crsSrc(src[2]), .rxDvSrc(src[3]),
    .receive_error_in(lvl[0]), .receive_error_out(pout[0]), .receive_error_oe(oe[0]),
    .colPinIn(lvl[1]), .colPinOut(pout[1]), .colPinOe(oe[1]),
    .crsPinIn(lvl[2]), .crsPinOut(pout[2]), .crsPinOe(oe[2]),
    .rxDvPinIn(lvl[3]), .rxDvPinOut(pout[3]), .rxDvPinOe(oe[3]),
    .txEnPin(txEnPin), .txDataPin(txDataPin), .txEnOut(txEnOut), .txDataOut(txDataOut),
    .setting_a(setting_a), .modeStrap(modeStrap), .strapDone(strapDone));
  task automatic endOfTest;
    $display("checks %0d mismatches %0d", samplesChecked, badCount);
    if (badCount == 0 && samplesChecked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      badCount++;
      endOfTest();
    end
  end
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    regAddr = a;
    regRdEn = 1'b1;
    tick(1);
    regRdEn = 1'b0;
    chk("rdata", regRdData, e);
    tick(1);
  endtask
  // straps as {rxDv,crs,col,rxErr}, then the strap result after capture
  task automatic strapRun(input logic [3:0] p);
    srst = 1'b1;
    pull = p;
    tick(20);
    srst = 1'b0;
    tick(2);
    chk("done", {15'h0000, strapDone}, 16'h0001);
    chk("iso", {15'h0000, setting_a}, {15'h0000, p[0]});
    chk("mode", {13'h0000, modeStrap}, {13'h0000, p[3:1]});
    chk("irq rst", {15'h0000, irqPin}, 16'h0001);
    chk("rd rst", regRdData, 16'h0000);
    src = ~p;
    tick(3);
    chk("pins", {12'h000, lvl}, {12'h000, p[0] ? p : ~p});
  endtask
  // active-high pin, event in the read cycle, enable read straight back
  task automatic irqHighRun;
    irqEvents = 8'h01;
    tick(1);
    irqEvents = 8'h00;
    tick(1);
    chk("irq high", {15'h0000, irqPin}, 16'h0001);
    regAddr = PMS_ADDR_IRQ_CTRL;
    regRdEn = 1'b1;
    irqEvents = 8'h01;
    tick(1);
    regRdEn = 1'b0;
    irqEvents = 8'h00;
    chk("rd race", regRdData, 16'h0101);
    tick(1);
    rd(PMS_ADDR_IRQ_CTRL, 16'h0101);
    chk("irq clr", {15'h0000, irqPin}, 16'h0000);
    wr(PMS_ADDR_IRQ_CTRL, 16'h8200);
    rd(PMS_ADDR_IRQ_CTRL, 16'h8200);
    irqEvents = 8'h80;
    tick(1);
    irqEvents = 8'h00;
    tick(1);
    chk("irq bit7", {15'h0000, irqPin}, 16'h0001);
  endtask
  task automatic irqRun;
    wr(PMS_ADDR_IRQ_CTRL, 16'h0100);
    irqEvents = 8'h03;
    tick(1);
    irqEvents = 8'h00;
    tick(1);
    chk("irq low", {15'h0000, irqPin}, 16'h0000);
    rd(PMS_ADDR_IRQ_CTRL, 16'h0103);
    tick(2);
    chk("irq idle", {15'h0000, irqPin}, 16'h0001);
    irqEvents = 8'h02;
    tick(1);
    irqEvents = 8'h00;
    tick(2);
    chk("masked", {15'h0000, irqPin}, 16'h0001);
    wr(PMS_ADDR_CTRL_TWO, 16'h0200);
    tick(2);
    chk("irq pol", {15'h0000, irqPin}, 16'h0000);
    rd(PMS_ADDR_CTRL_TWO, 16'h0200);
    rd(5'h05, 16'h0000);
    rd(PMS_ADDR_IRQ_CTRL, 16'h0102);
  endtask
  task automatic txRun(input logic mode, input logic [3:0] e);
    rmiiMode = mode;
    txNib = 4'hF;
    txGo = 1'b1;
    tick(3);
    chk("tx", {11'h000, txEnOut, txDataOut}, {11'h000, 1'b1, e});
    txGo = 1'b0;
    tick(3);
    chk("tx idle", {15'h0000, txEnOut}, 16'h0000);
  endtask
  initial begin
    strapRun(4'hA);
    irqRun();
    irqHighRun();
    txRun(1'b1, 4'h3);
    txRun(1'b0, 4'hF);
    strapRun(4'h5);
    endOfTest();
  end
endmodule // testbench
